// file: rtl/pcrs_pkg.sv
package pcrs_pkg;

  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam int STACK_DEPTH = 31;
  localparam int INSTR_W = 16;
  localparam int CFG_WORDS = 4;
  localparam int PMEM_KBYTES_DEF = 128;
  localparam int KBYTE = 1024;

  localparam logic [20:0] RESET_VEC = 21'h000000;
  localparam logic [20:0] HI_IRQ_VEC = 21'h000008;
  localparam logic [20:0] LO_IRQ_VEC = 21'h000018;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] WORD_ALIGN = 21'h1FFFFE;
  localparam logic [20:0] CFG_SPAN = 21'h000008;
  localparam logic [7:0] BYTE_ALIGN = 8'hFE;

  localparam logic [4:0] SP_EMPTY = 5'h00;
  localparam logic [4:0] SP_TOP = 5'h1F;
  localparam logic [4:0] SP_ONE = 5'h01;
  localparam int SP_FULL_BIT = 7;
  localparam int SP_UNF_BIT = 6;
  localparam int OVF_RST_BIT = 5;
  localparam logic [2:0] CFG_DONE_CNT = 3'h4;
  localparam logic [2:0] CFG_CNT_ONE = 3'h1;

  typedef enum logic [3:0] {
    OP_NONE, OP_SEQ, OP_JUMP, OP_CALL, OP_IRQ_HI, OP_IRQ_LO,
    OP_RETURN, OP_UNLINK, OP_PUSH, OP_POP
  } pcrs_op_e;

  typedef struct packed {
    pcrs_op_e op;
    logic [20:0] target;
  } pcrs_cmd_s;

  typedef struct packed {
    logic wr_pcl;
    logic rd_pcl;
    logic wr_lath;
    logic wr_latu;
    logic wr_sp;
    logic wr_stack_top_upper;
    logic wr_stack_top_high;
    logic wr_stack_top_low;
    logic [7:0] data;
  } pcrs_sfr_s;

  typedef struct packed {
    logic [7:0] counter_low_byte;
    logic [7:0] sp_reg;
    logic [7:0] stack_top_upper;
    logic [7:0] stack_top_high;
    logic [7:0] stack_top_low;
    logic [7:0] lath;
    logic [7:0] latu;
  } pcrs_rd_s;

endpackage : pcrs_pkg

// file: rtl/pcrs_stack_mem.sv
`timescale 1ns/1ps
module pcrs_stack_mem #(
  parameter int DEPTH = pcrs_pkg::STACK_DEPTH,
  parameter int WIDTH = pcrs_pkg::PC_W
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [pcrs_pkg::SP_W-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read port
  input wire logic [pcrs_pkg::SP_W-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  import pcrs_pkg::*;

  if (DEPTH < 1 || DEPTH >= (1 << SP_W)) begin : g_chk
    $error("stack depth out of range");
  end

  // ----------------------------------------
  // storage, entries 1..DEPTH only
  // ----------------------------------------
  logic [WIDTH-1:0] mem [1:DEPTH];

  always_ff @(posedge clk) begin
    if (we && waddr != SP_EMPTY && int'(waddr) <= DEPTH) begin
      mem[waddr] <= wdata;
    end
  end

  always_comb begin
    rdata = '0;
    if (raddr != SP_EMPTY && int'(raddr) <= DEPTH) begin
      rdata = mem[raddr];
    end
  end

endmodule : pcrs_stack_mem

// file: rtl/pcrs_cfg_load.sv
`timescale 1ns/1ps
module pcrs_cfg_load #(
  parameter logic [20:0] CFG_BASE = 21'h01FFF8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // restart after a device reset
  input wire logic start,
  // program memory word seen at the fetch address
  input wire logic [pcrs_pkg::INSTR_W-1:0] rdata,
  output logic [20:0] req_addr,
  // captured configuration
  output logic [pcrs_pkg::CFG_WORDS-1:0][pcrs_pkg::INSTR_W-1:0] cfg_words,
  output logic ready
);
  import pcrs_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
    logic ready;
    logic [CFG_WORDS-1:0][INSTR_W-1:0] words;
  } pcrs_cfg_state_s;

  pcrs_cfg_state_s s_ff;
  pcrs_cfg_state_s nxt_s;

  // ----------------------------------------
  // walk the last four words upward
  // ----------------------------------------
  always_comb begin
    nxt_s = s_ff;
    req_addr = CFG_BASE + {17'h00000, s_ff.cnt, 1'b0};
    if (start) begin
      nxt_s.cnt = '0;
      nxt_s.ready = 1'b0;
    end else if (!s_ff.ready) begin
      if (s_ff.cnt != '0) begin
        nxt_s.words[s_ff.cnt - CFG_CNT_ONE] = rdata;
      end
      if (s_ff.cnt == CFG_DONE_CNT) begin
        nxt_s.ready = 1'b1;
      end else begin
        nxt_s.cnt = s_ff.cnt + CFG_CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign cfg_words = s_ff.words;
  assign ready = s_ff.ready;

endmodule : pcrs_cfg_load

// file: rtl/pcrs_top.sv
`timescale 1ns/1ps
module pcrs_top #(
  parameter int PMEM_KBYTES = pcrs_pkg::PMEM_KBYTES_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic dev_reset,
  // decoder side
  input wire pcrs_pkg::pcrs_cmd_s cmd,
  input wire logic ext_set_en,
  input wire pcrs_pkg::pcrs_sfr_s sfr,
  // special register views
  output pcrs_pkg::pcrs_rd_s rd_ff,
  output logic [pcrs_pkg::PC_W-1:0] program_counter_ff,
  // program memory
  output logic [pcrs_pkg::PC_W-1:0] fetch_addr_ff,
  input wire logic [pcrs_pkg::INSTR_W-1:0] flash_rdata,
  output logic [pcrs_pkg::INSTR_W-1:0] instr_ff,
  // configuration and status
  output logic [pcrs_pkg::CFG_WORDS-1:0][pcrs_pkg::INSTR_W-1:0] cfg_words,
  output logic cfg_ready,
  output logic stack_reset_ff
);
  import pcrs_pkg::*;

  if (PMEM_KBYTES != 64 && PMEM_KBYTES != 128) begin : g_chk
    $error("PMEM_KBYTES must be 64 or 128");
  end

  localparam logic [21:0] MEM_TOP = 22'(PMEM_KBYTES * KBYTE);
  localparam logic [20:0] CFG_BASE = MEM_TOP[20:0] - CFG_SPAN;

  typedef struct packed {
    logic [20:0] pc;
    logic [7:0] lath;
    logic [4:0] latu;
    logic [4:0] sp;
    logic full;
    logic unf;
    pcrs_rd_s rd;
    logic [20:0] fetch_addr;
    logic [15:0] instr;
    logic stk_rst;
  } pcrs_top_state_s;

  pcrs_top_state_s s_ff;
  pcrs_top_state_s nxt_s;

  logic [20:0] stack_top_entry;
  logic [20:0] cfg_addr;
  logic stk_we;
  logic [4:0] stk_waddr;
  logic [20:0] stk_wdata;
  logic ovf_rst_en;
  logic push_en;
  logic [20:0] push_val;
  logic pop_en;
  logic pop_keep_pc;
  logic [4:0] sp_inc;

  // ----------------------------------------
  // return stack storage
  // ----------------------------------------
  pcrs_stack_mem #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W)
  ) u_stack (
    .clk(clk),
    .we(stk_we),
    .waddr(stk_waddr),
    .wdata(stk_wdata),
    .raddr(s_ff.sp),
    .rdata(stack_top_entry)
  );

  // ----------------------------------------
  // configuration copy at reset
  // ----------------------------------------
  pcrs_cfg_load #(
    .CFG_BASE(CFG_BASE)
  ) u_cfg (
    .clk(clk),
    .rstn(rstn),
    .start(dev_reset | s_ff.stk_rst),
    .rdata(flash_rdata),
    .req_addr(cfg_addr),
    .cfg_words(cfg_words),
    .ready(cfg_ready)
  );

  assign ovf_rst_en = cfg_words[0][OVF_RST_BIT];

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.stk_rst = 1'b0;
    stk_we = 1'b0;
    stk_waddr = s_ff.sp;
    stk_wdata = stack_top_entry;
    push_en = 1'b0;
    push_val = s_ff.pc;
    pop_en = 1'b0;
    pop_keep_pc = 1'b0;
    sp_inc = s_ff.sp + SP_ONE;

    if (dev_reset) begin
      nxt_s.pc = RESET_VEC;
      nxt_s.sp = SP_EMPTY;
      nxt_s.lath = '0;
      nxt_s.latu = '0;
    end else if (cfg_ready) begin
      // software register accesses
      if (sfr.wr_lath) begin
        nxt_s.lath = sfr.data;
      end
      if (sfr.wr_latu) begin
        nxt_s.latu = sfr.data[4:0];
      end
      if (sfr.rd_pcl) begin
        nxt_s.lath = s_ff.pc[15:8];
        nxt_s.latu = s_ff.pc[20:16];
      end
      if (sfr.wr_pcl) begin
        nxt_s.pc = {s_ff.latu, s_ff.lath, sfr.data & BYTE_ALIGN};
      end
      if (sfr.wr_sp) begin
        nxt_s.sp = sfr.data[4:0];
        nxt_s.full = s_ff.full & sfr.data[SP_FULL_BIT];
        nxt_s.unf = s_ff.unf & sfr.data[SP_UNF_BIT];
      end
      if (sfr.wr_stack_top_upper || sfr.wr_stack_top_high || sfr.wr_stack_top_low) begin
        stk_we = 1'b1;
        if (sfr.wr_stack_top_upper) begin
          stk_wdata[20:16] = sfr.data[4:0];
        end
        if (sfr.wr_stack_top_high) begin
          stk_wdata[15:8] = sfr.data;
        end
        if (sfr.wr_stack_top_low) begin
          stk_wdata[7:0] = sfr.data;
        end
      end

      // program flow
      case (cmd.op)
        OP_SEQ: begin
          nxt_s.pc = (s_ff.pc + PC_STEP) & WORD_ALIGN;
        end
        OP_JUMP: begin
          nxt_s.pc = cmd.target & WORD_ALIGN;
        end
        OP_CALL: begin
          push_en = 1'b1;
          nxt_s.pc = cmd.target & WORD_ALIGN;
        end
        OP_IRQ_HI: begin
          push_en = 1'b1;
          nxt_s.pc = HI_IRQ_VEC;
        end
        OP_IRQ_LO: begin
          push_en = 1'b1;
          nxt_s.pc = LO_IRQ_VEC;
        end
        OP_RETURN: begin
          pop_en = 1'b1;
        end
        OP_UNLINK: begin
          pop_en = ext_set_en;
        end
        OP_PUSH: begin
          push_en = 1'b1;
        end
        OP_POP: begin
          pop_en = 1'b1;
          pop_keep_pc = 1'b1;
        end
        default: begin
          // idle: keep whatever the register writes chose
          nxt_s.stk_rst = 1'b0;
        end
      endcase

      // push: pointer first, then the entry
      if (push_en) begin
        if (s_ff.sp == SP_TOP) begin
          nxt_s.full = 1'b1;
          nxt_s.sp = SP_TOP;
        end else begin
          stk_we = 1'b1;
          stk_waddr = sp_inc;
          stk_wdata = push_val;
          nxt_s.sp = sp_inc;
          if (sp_inc == SP_TOP) begin
            nxt_s.full = 1'b1;
            if (ovf_rst_en) begin
              nxt_s.sp = SP_EMPTY;
              nxt_s.pc = RESET_VEC;
              nxt_s.stk_rst = 1'b1;
            end
          end
        end
      end

      // pop: entry first, then the pointer
      if (pop_en) begin
        if (s_ff.sp == SP_EMPTY) begin
          nxt_s.unf = 1'b1;
          if (!pop_keep_pc) begin
            nxt_s.pc = RESET_VEC;
          end
          if (ovf_rst_en) begin
            nxt_s.stk_rst = 1'b1;
          end
        end else begin
          if (!pop_keep_pc) begin
            nxt_s.pc = stack_top_entry & WORD_ALIGN;
          end
          nxt_s.sp = s_ff.sp - SP_ONE;
        end
      end
    end

    // a stack reset also resets the counter latches
    if (nxt_s.stk_rst) begin
      nxt_s.lath = '0;
      nxt_s.latu = '0;
    end

    // register views
    nxt_s.rd.counter_low_byte = s_ff.pc[7:0];
    nxt_s.rd.sp_reg = {s_ff.full, s_ff.unf, 1'b0, s_ff.sp};
    nxt_s.rd.stack_top_upper = {3'h0, stack_top_entry[20:16]};
    nxt_s.rd.stack_top_high = stack_top_entry[15:8];
    nxt_s.rd.stack_top_low = stack_top_entry[7:0];
    nxt_s.rd.lath = s_ff.lath;
    nxt_s.rd.latu = {3'h0, s_ff.latu};

    // fetch path
    if (!cfg_ready) begin
      nxt_s.fetch_addr = cfg_addr;
    end else begin
      nxt_s.fetch_addr = nxt_s.pc;
    end
    if ({1'b0, s_ff.fetch_addr} >= MEM_TOP) begin
      nxt_s.instr = '0;
    end else begin
      nxt_s.instr = flash_rdata;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rd_ff = s_ff.rd;
  assign program_counter_ff = s_ff.pc;
  assign fetch_addr_ff = s_ff.fetch_addr;
  assign instr_ff = s_ff.instr;
  assign stack_reset_ff = s_ff.stk_rst;

endmodule : pcrs_top

// file: verification/pcrs_pmem_model.sv
`timescale 1ns/1ps
module pcrs_pmem_model #(
  parameter int TOP = 65536
) (
  // fetch side
  input wire logic [20:0] addr,
  input wire logic ovf_en,
  output logic [15:0] rdata
);
  // ----
  // word per address, low byte at even address
  // ----
  always_comb begin
    rdata = addr[15:0] ^ 16'h5A5A;
    if (addr == 21'(TOP - 8)) begin
      rdata[5] = ovf_en;
    end
  end
endmodule : pcrs_pmem_model

// file: verification/pcrs_top_chk.sv
`timescale 1ns/1ps
module pcrs_top_chk #(
  parameter int PMEM_KBYTES = 128
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic dev_reset,
  input wire pcrs_pkg::pcrs_cmd_s cmd,
  input wire pcrs_pkg::pcrs_sfr_s sfr,
  input wire pcrs_pkg::pcrs_rd_s rd_ff,
  input wire logic [20:0] program_counter_ff,
  input wire logic [20:0] fetch_addr_ff,
  input wire logic [15:0] instr_ff,
  input wire logic cfg_ready,
  input wire logic stack_reset_ff
);
  import pcrs_pkg::*;
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  localparam int TOP = PMEM_KBYTES * KBYTE;
  wire go = cfg_ready && !dev_reset;
  property p_align;
    program_counter_ff[0] == 1'b0;
  endproperty
  property p_seq;
    go && cmd.op == OP_SEQ && !sfr.wr_pcl |=> program_counter_ff == $past(program_counter_ff) + PC_STEP;
  endproperty
  property p_jump;
    go && cmd.op == OP_JUMP |=> program_counter_ff == ($past(cmd.target) & WORD_ALIGN);
  endproperty
  property p_irq;
    go && cmd.op == OP_IRQ_HI |=> stack_reset_ff || program_counter_ff == HI_IRQ_VEC;
  endproperty
  property p_irq_lo;
    go && cmd.op == OP_IRQ_LO |=> stack_reset_ff || program_counter_ff == LO_IRQ_VEC;
  endproperty
  property p_devrst;
    dev_reset |=> program_counter_ff == RESET_VEC && !cfg_ready;
  endproperty
  property p_nofetch;
    go && fetch_addr_ff >= 21'(TOP) |=> instr_ff == 16'h0000;
  endproperty
  property p_ready;
    !cfg_ready && !dev_reset |-> ##[1:8] cfg_ready;
  endproperty
  sequence s_srst;
    (program_counter_ff == RESET_VEC) ##1 !stack_reset_ff;
  endsequence
  property p_stkrst;
    stack_reset_ff |-> s_srst;
  endproperty
  property p_bit5;
    rd_ff.sp_reg[5] == 1'b0;
  endproperty
  property p_latch;
    go && cmd.op inside {OP_CALL, OP_RETURN} && sfr[15:12] == 4'h0
      |=> ##1 ($stable(rd_ff.lath) || $past(stack_reset_ff));
  endproperty
  a_align: assert property (p_align) else $error("pc odd");
  a_seq: assert property (p_seq) else $error("pc step");
  a_jump: assert property (p_jump) else $error("jump");
  a_irq: assert property (p_irq) else $error("hi vector");
  a_irq_lo: assert property (p_irq_lo) else $error("lo vector");
  a_devrst: assert property (p_devrst) else $error("dev reset");
  a_nofetch: assert property (p_nofetch) else $error("fetch");
  a_ready: assert property (p_ready) else $error("cfg load");
  a_stkrst: assert property (p_stkrst) else $error("stack reset");
  a_bit5: assert property (p_bit5) else $error("bit5");
  a_latch: assert property (p_latch) else $error("latch");
endmodule : pcrs_top_chk
bind pcrs_top pcrs_top_chk #(.PMEM_KBYTES(PMEM_KBYTES)) u_pcrs_top_chk (.clk, .rstn,
  .dev_reset, .cmd, .sfr, .rd_ff, .program_counter_ff, .fetch_addr_ff, .instr_ff,
  .cfg_ready, .stack_reset_ff);

// file: verification/program_counter_return_stack_test.sv
`timescale 1ns/1ps
module program_counter_return_stack_test;
  import pcrs_pkg::*;
  // ----
  // harness
  // ----
  localparam int TOP = 64 * KBYTE;
  typedef struct packed {
    pcrs_op_e op;
    logic ext;
    logic [20:0] tgt;
    logic [20:0] pc;
    logic [7:0] sp;
  } pcrs_row_s;
  pcrs_row_s rows [12] = '{
    '{OP_JUMP, 1'h0, 21'h012345, 21'h012344, 8'h00},
    '{OP_SEQ, 1'h0, 21'h000000, 21'h012346, 8'h00},
    '{OP_CALL, 1'h0, 21'h001000, 21'h001000, 8'h01},
    '{OP_IRQ_HI, 1'h0, 21'h000000, 21'h000008, 8'h02},
    '{OP_IRQ_LO, 1'h0, 21'h000000, 21'h000018, 8'h03},
    '{OP_RETURN, 1'h0, 21'h000000, 21'h000008, 8'h02},
    '{OP_UNLINK, 1'h0, 21'h000000, 21'h000008, 8'h02},
    '{OP_UNLINK, 1'h1, 21'h000000, 21'h001000, 8'h01},
    '{OP_PUSH, 1'h0, 21'h000000, 21'h001000, 8'h02},
    '{OP_POP, 1'h0, 21'h000000, 21'h001000, 8'h01},
    '{OP_RETURN, 1'h0, 21'h000000, 21'h012346, 8'h00},
    '{OP_RETURN, 1'h0, 21'h000000, 21'h000000, 8'h40}};
  logic clk = 0, rstn = 0, dev_reset = 0, ext_set_en = 0, ovf = 0;
  logic cfg_ready, stack_reset_ff;
  pcrs_cmd_s cmd = '0;
  pcrs_sfr_s sfr = '0;
  pcrs_rd_s rd_ff;
  logic [20:0] program_counter_ff, fetch_addr_ff;
  logic [15:0] flash_rdata, instr_ff, e;
  logic [3:0][15:0] cfg_words;
  int num_errors = 0, total_checks = 0, cyc = 0, n_srst = 0;
  always #5 clk = ~clk;
  pcrs_top #(.PMEM_KBYTES(64)) u_pcrs_top (.clk, .rstn, .dev_reset, .cmd, .ext_set_en,
    .sfr, .rd_ff, .program_counter_ff, .fetch_addr_ff, .flash_rdata, .instr_ff,
    .cfg_words, .cfg_ready, .stack_reset_ff);
  pcrs_pmem_model #(.TOP(TOP)) u_pcrs_pmem_model (.addr(fetch_addr_ff), .ovf_en(ovf),
    .rdata(flash_rdata));
  always @(posedge clk) begin
    cyc++;
    if (stack_reset_ff === 1'b1) n_srst++;
    if (cyc == 3000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic op(input pcrs_op_e o, input logic [20:0] t);
    cmd = {o, t};
    @(posedge clk);
    #1 cmd.op = OP_NONE;
    @(posedge clk);
    #1;
  endtask : op
  task automatic sw(input logic [7:0] m, input logic [7:0] d);
    sfr = {m, d};
    @(posedge clk);
    #1 sfr = '0;
    @(posedge clk);
    #1;
  endtask : sw
  task automatic wt;
    for (int i = 0; i < 20 && cfg_ready !== 1'b1; i++) @(posedge clk);
    #1 chk(cfg_ready, 1);
  endtask : wt
  task automatic finish_test;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  // ----
  // tests
  // ----
  initial begin
    repeat (8) @(posedge clk);
    #1 rstn = 1;
    wt();
    chk(program_counter_ff, 0);
    chk(rd_ff.sp_reg, 0);
    for (int i = 0; i < 4; i++) begin
      e = 16'(TOP - 8 + 2 * i) ^ 16'h5A5A;
      if (i == 0) e[5] = ovf;
      chk(cfg_words[i], e);
    end
    $display("reset done");
    foreach (rows[i]) begin
      ext_set_en = rows[i].ext;
      op(rows[i].op, rows[i].tgt);
      chk(program_counter_ff, rows[i].pc);
      chk(rd_ff.sp_reg, rows[i].sp);
    end
    $display("rows done");
    sw(8'h08, 8'h00);
    chk(rd_ff.sp_reg, 0);
    sw(8'h20, 8'h34);
    sw(8'h10, 8'h12);
    sw(8'h80, 8'h57);
    chk(program_counter_ff, 21'h123456);
    chk(rd_ff.counter_low_byte, 8'h56);
    op(OP_JUMP, 21'h010000);
    chk(instr_ff, 0);
    sw(8'h40, 8'h00);
    chk({rd_ff.latu, rd_ff.lath}, 16'h0100);
    op(OP_JUMP, 21'h000100);
    chk(instr_ff, 16'h5B5A);
    chk(fetch_addr_ff, 21'h000100);
    $display("latch done");
    for (int i = 1; i <= 32; i++) op(OP_CALL, 21'(i * 16));
    @(posedge clk);
    #1 chk(rd_ff.sp_reg, 8'h9F);
    chk({rd_ff.stack_top_upper, rd_ff.stack_top_high, rd_ff.stack_top_low}, 24'h0001E0);
    sw(8'h01, 8'h42);
    @(posedge clk);
    #1 chk(rd_ff.stack_top_low, 8'h42);
    sw(8'h08, 8'h00);
    chk(rd_ff.sp_reg, 0);
    $display("full done");
    ovf = 1;
    dev_reset = 1;
    @(posedge clk);
    #1 dev_reset = 0;
    repeat (2) @(posedge clk);
    wt();
    for (int i = 1; i <= 31; i++) op(OP_CALL, 21'(i * 16));
    repeat (3) @(posedge clk);
    wt();
    chk(n_srst, 1);
    chk(rd_ff.sp_reg, 8'h80);
    op(OP_RETURN, 0);
    repeat (3) @(posedge clk);
    wt();
    chk(program_counter_ff, 0);
    chk(rd_ff.sp_reg, 8'hC0);
    $display("overflow reset done");
    finish_test();
  end
endmodule : program_counter_return_stack_test
